/* core/wdsr_top.sv */
// How it works
// - key 5A then A5 resets device
// - soft reset works with watchdog stopped
// - soft reset sets soft flag only
// - wrong key sequence resets, sets both flags
// - select 0 gives 16K, 7 gives 2048K
// - idle freeze bit holds counter in idle
// - flags survive reset until software clears
// - key 1E then E1 starts watchdog
// - enable pair again restarts interval
// - unrefreshed time-out resets, sets overflow flag
// - running bit read-only, shows counter active
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "wdsr_consts.svh"

module wdsr_top
	import wdsr_pkg::*;
#(
	parameter int CNT_W = `WDSR_CNT_W
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        idle_mode,
	input  wire logic        other_reset_n,
	output logic             wdt_reset_req
);
	// Longest select needs base plus top select value in counter bits
	if (CNT_W < `WDSR_BASE_LOG2 + `WDSR_PS_MAX) begin
		$error("CNT_W too small for the longest time-out");
	end

	localparam logic [7:0] CTRL_RESET   = `WDSR_CTRL_RESET;
	localparam logic [2:0] PERIOD_RESET = CTRL_RESET[`WDSR_PS_MSB:`WDSR_PS_LSB];
	localparam logic       IDLE_RESET   = CTRL_RESET[`WDSR_IDLE_BIT];
	localparam logic       SOFT_RESET   = CTRL_RESET[`WDSR_SOFT_BIT];
	localparam logic       OVF_RESET    = CTRL_RESET[`WDSR_OVF_BIT];
	localparam logic       RUN_RESET    = CTRL_RESET[`WDSR_RUN_BIT];

	logic [2:0]       period_reg;
	logic             idle_freeze_reg;
	logic             soft_flag_reg;
	logic             ovf_flag_reg;
	logic             running_reg;
	logic [CNT_W-1:0] count_reg;
	logic [3:0]       pulse_reg;
	logic             idle_s1_reg;
	logic             idle_s2_reg;
	logic             orst_s1_reg;
	logic             orst_s2_reg;

	logic             wr_en;
	logic             wr_key;
	logic             wr_ctrl;
	logic             rd_ctrl;
	logic             addr_hit;
	logic             is_key;
	logic             is_ctrl;
	logic             count_hold;
	logic             key_enable;
	logic             key_reset;
	logic             key_error;
	logic             timeout;
	logic             any_reset;
	logic [CNT_W-1:0] limit;

	function automatic logic [CNT_W-1:0] wdsr_limit(input logic [2:0] sel);
		logic [CNT_W-1:0] one;
		one = {{(CNT_W-1){1'b0}}, 1'b1};
		wdsr_limit = (one << (`WDSR_BASE_LOG2 + sel)) - one;
	endfunction

	// Upper bits must be zero, so aliases of the two registers stay unmapped
	function automatic logic wdsr_addr_is(input logic [31:0] addr, input logic [`WDSR_ADDR_W-1:0] offset);
		wdsr_addr_is = (addr[31:`WDSR_ADDR_W] == '0) && (addr[`WDSR_ADDR_W-1:0] == offset);
	endfunction

	// Bus: zero wait, byte lane 0 carries the 8-bit registers
	assign pready   = 1'b1;
	assign is_key   = wdsr_addr_is(paddr, `WDSR_KEY_ADDR);
	assign is_ctrl  = wdsr_addr_is(paddr, `WDSR_CTRL_ADDR);
	assign addr_hit = is_key || is_ctrl;
	// Key register is write-only, a read of it is refused
	assign pslverr  = psel && penable && (!addr_hit || (!pwrite && is_key));
	assign wr_en    = psel && penable && pwrite && pstrb[0] && clk_en;
	assign wr_key   = wr_en && is_key;
	assign wr_ctrl  = wr_en && is_ctrl;
	assign rd_ctrl  = psel && !penable && !pwrite && is_ctrl;

	wdsr_key_seq u_key (
		.pclk       (pclk),
		.presetn    (presetn),
		.clk_en     (clk_en),
		.clear      (any_reset),
		.key_wr     (wr_key),
		.key_data   (pwdata[7:0]),
		.key_enable (key_enable),
		.key_reset  (key_reset),
		.key_error  (key_error)
	);

	// Idle level arrives from another domain: two flops before any use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_s1_reg <= 1'b0;
			idle_s2_reg <= 1'b0;
		end else if (clk_en) begin
			idle_s1_reg <= idle_mode;
			idle_s2_reg <= idle_s1_reg;
		end
	end

	// Other reset sources, same treatment; idles high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			orst_s1_reg <= 1'b1;
			orst_s2_reg <= 1'b1;
		end else if (clk_en) begin
			orst_s1_reg <= other_reset_n;
			orst_s2_reg <= orst_s1_reg;
		end
	end

	assign limit      = wdsr_limit(period_reg);
	assign count_hold = idle_freeze_reg && idle_s2_reg;
	// interval elapsed
	// At or past the limit, so a shorter period set mid-count still fires
	assign timeout    = running_reg && (count_reg >= limit);
	// key reset independent of running state
	assign any_reset  = key_reset || key_error || timeout || !orst_s2_reg;

	// Period select, cleared by every reset source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_reg <= PERIOD_RESET;
		end else if (clk_en) begin
			if (any_reset) begin
				period_reg <= PERIOD_RESET;
			end else if (wr_ctrl) begin
				period_reg <= pwdata[`WDSR_PS_MSB:`WDSR_PS_LSB];
			end
		end
	end

	// Idle freeze bit, cleared by every reset source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_freeze_reg <= IDLE_RESET;
		end else if (clk_en) begin
			if (any_reset) begin
				idle_freeze_reg <= IDLE_RESET;
			end else if (wr_ctrl) begin
				idle_freeze_reg <= pwdata[`WDSR_IDLE_BIT];
			end
		end
	end

	// flags kept across block resets; set beats clear
	// overflow flag untouched by good key
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_flag_reg <= SOFT_RESET;
		end else if (clk_en) begin
			if (key_reset || key_error) begin
				soft_flag_reg <= 1'b1;
			end else if (wr_ctrl && !pwdata[`WDSR_SOFT_BIT]) begin
				soft_flag_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_flag_reg <= OVF_RESET;
		end else if (clk_en) begin
			if (key_error || timeout) begin
				ovf_flag_reg <= 1'b1;
			end else if (wr_ctrl && !pwdata[`WDSR_OVF_BIT]) begin
				ovf_flag_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running_reg <= RUN_RESET;
		end else if (clk_en) begin
			if (any_reset) begin
				running_reg <= 1'b0;
			end else if (key_enable) begin
				running_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
		end else if (clk_en) begin
			if (any_reset || key_enable || !running_reg) begin
				count_reg <= '0;
			end else if (!count_hold) begin
				count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Stretched pulse so the system reset logic cannot miss it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_reg <= 4'h0;
		end else if (clk_en) begin
			if (key_reset || key_error || timeout) begin
				pulse_reg <= `WDSR_RST_PULSE;
			end else if (pulse_reg != 4'h0) begin
				pulse_reg <= pulse_reg - 4'h1;
			end
		end
	end

	assign wdt_reset_req = (pulse_reg != 4'h0);

	// running bit read-only status
	// Loaded in the setup cycle, so it stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (clk_en) begin
			if (rd_ctrl) begin
				prdata <= {24'h0, period_reg, idle_freeze_reg, 1'b0,
				           soft_flag_reg, ovf_flag_reg, running_reg};
			end else if (!psel) begin
				prdata <= 32'h0;
			end
		end
	end
endmodule
`default_nettype wire

/* core/wdsr_consts.svh */
`ifndef WDSR_CONSTS_SVH
`define WDSR_CONSTS_SVH

// Register byte addresses (printed offsets are not multiples of four: index*4)
`define WDSR_KEY_INDEX       8'hA6
`define WDSR_CTRL_INDEX      8'hA7
`define WDSR_ADDR_W          10
`define WDSR_KEY_ADDR        10'h298
`define WDSR_CTRL_ADDR       10'h29C

// Key bytes
`define WDSR_KEY_EN_FIRST    8'h1E
`define WDSR_KEY_EN_SECOND   8'hE1
`define WDSR_KEY_RST_FIRST   8'h5A
`define WDSR_KEY_RST_SECOND  8'hA5

// Control register fields
`define WDSR_PS_MSB          7
`define WDSR_PS_LSB          5
`define WDSR_IDLE_BIT        4
`define WDSR_SOFT_BIT        2
`define WDSR_OVF_BIT         1
`define WDSR_RUN_BIT         0
`define WDSR_CTRL_RESET      8'h00

// Base time-out: 16K cycles, doubled per select step
`define WDSR_BASE_LOG2       14
`define WDSR_PS_MAX          3'h7
`define WDSR_CNT_W           21

// Length of the reset pulse driven out
`define WDSR_RST_PULSE       4'h4

`endif

/* core/wdsr_pkg.sv */
package wdsr_pkg;
	typedef enum logic [2:0] {
		WDSR_KEY_IDLE = 3'b001,
		WDSR_KEY_EN   = 3'b010,
		WDSR_KEY_RST  = 3'b100
	} wdsr_key_state_t;
endpackage

/* core/wdsr_key_seq.sv */
`timescale 1ns/10ps
`default_nettype none
`include "wdsr_consts.svh"

module wdsr_key_seq
	import wdsr_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       clk_en,
	input  wire logic       clear,
	input  wire logic       key_wr,
	input  wire logic [7:0] key_data,
	output logic            key_enable,
	output logic            key_reset,
	output logic            key_error
);
	wdsr_key_state_t state_reg;
	wdsr_key_state_t state_next;

	always_comb begin
		state_next = state_reg;
		key_enable = 1'b0;
		key_reset  = 1'b0;
		key_error  = 1'b0;
		if (key_wr) begin
			case (state_reg)
				WDSR_KEY_IDLE: begin
					if (key_data == `WDSR_KEY_EN_FIRST)
						state_next = WDSR_KEY_EN;
					else if (key_data == `WDSR_KEY_RST_FIRST)
						state_next = WDSR_KEY_RST;
					else
						key_error = 1'b1;
				end
				WDSR_KEY_EN: begin
					state_next = WDSR_KEY_IDLE;
					key_enable = (key_data == `WDSR_KEY_EN_SECOND);
					key_error  = (key_data != `WDSR_KEY_EN_SECOND);
				end
				WDSR_KEY_RST: begin
					state_next = WDSR_KEY_IDLE;
					key_reset  = (key_data == `WDSR_KEY_RST_SECOND);
					key_error  = (key_data != `WDSR_KEY_RST_SECOND);
				end
				default: begin
					state_next = WDSR_KEY_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= WDSR_KEY_IDLE;
		else if (clk_en) begin
			if (clear)
				state_reg <= WDSR_KEY_IDLE;
			else
				state_reg <= state_next;
		end
	end
endmodule
`default_nettype wire

/* tb/wdsr_chk.sv */
`timescale 1ns/10ps
`default_nettype none
`include "wdsr_consts.svh"
module wdsr_chk #(
	parameter int CNT_W = 21
)(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        idle_mode,
	input wire logic        other_reset_n,
	input wire logic        wdt_reset_req
);
	localparam logic [31:0] KA = {22'h0, `WDSR_KEY_ADDR};
	localparam logic [31:0] CA = {22'h0, `WDSR_CTRL_ADDR};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] first_reg;
	logic       key_acc;
	logic       key_bad;
	assign key_acc = psel && penable && clk_en && pwrite && pstrb[0] && paddr == KA;
	// first byte of a pair, as software sent it
	always_comb begin
		key_bad = 1'b0;
		if (first_reg == 8'h00)
			key_bad = !(pwdata[7:0] inside {`WDSR_KEY_EN_FIRST, `WDSR_KEY_RST_FIRST});
		else if (first_reg == `WDSR_KEY_EN_FIRST)
			key_bad = pwdata[7:0] != `WDSR_KEY_EN_SECOND;
		else
			key_bad = pwdata[7:0] != `WDSR_KEY_RST_SECOND;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			first_reg <= 8'h00;
		else if (wdt_reset_req || !other_reset_n)
			first_reg <= 8'h00;
		else if (key_acc && first_reg == 8'h00 && !key_bad)
			first_reg <= pwdata[7:0];
		else if (key_acc)
			first_reg <= 8'h00;
	end
	sequence s_acc;
		psel && penable && clk_en;
	endsequence
	sequence s_key(d);
		s_acc ##0 pwrite && pstrb[0] && paddr == KA && pwdata[7:0] == d;
	endsequence
	property p_soft;
		s_key(`WDSR_KEY_RST_SECOND) ##0 first_reg == `WDSR_KEY_RST_FIRST |-> ##1 wdt_reset_req;
	endproperty
	property p_bad;
		key_acc && key_bad |-> ##1 wdt_reset_req;
	endproperty
	property p_en_pair;
		s_key(`WDSR_KEY_EN_SECOND) ##0 first_reg == `WDSR_KEY_EN_FIRST && !wdt_reset_req |-> ##1 !wdt_reset_req;
	endproperty
	property p_pulse;
		$rose(wdt_reset_req) |-> wdt_reset_req[*4] ##1 !wdt_reset_req;
	endproperty
	property p_unmapped;
		s_acc ##0 paddr != KA && paddr != CA |-> pslverr;
	endproperty
	property p_key_rd;
		s_acc ##0 !pwrite && paddr == KA |-> pslverr;
	endproperty
	property p_ctrl;
		s_acc ##0 paddr == CA |-> !pslverr && (pwrite || prdata[31:8] == 24'h0 && !prdata[3]);
	endproperty
	property p_rd_idle;
		!psel && $past(!psel) |-> prdata == 32'h0;
	endproperty
	property p_ready;
		psel |-> pready;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset pair gave no reset");
	a_bad: assert property (p_bad) else $error("bad key gave no reset");
	a_en_pair: assert property (p_en_pair) else $error("enable pair gave a reset");
	a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");
	a_key_rd: assert property (p_key_rd) else $error("key register readable");
	a_ctrl: assert property (p_ctrl) else $error("control access wrong");
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
	a_ready: assert property (p_ready) else $error("pready low");
endmodule
bind wdsr_top wdsr_chk #(.CNT_W(CNT_W)) i_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
	.other_reset_n(other_reset_n), .wdt_reset_req(wdt_reset_req));
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "wdsr_consts.svh"
module tb;
	localparam logic [31:0] KA = {22'h0, `WDSR_KEY_ADDR};
	localparam logic [31:0] CA = {22'h0, `WDSR_CTRL_ADDR};
	logic        pclk, presetn, psel, penable, pwrite, idle_mode, other_reset_n, clk_en;
	logic        pready, pslverr, wdt_reset_req, err, hit;
	logic [31:0] paddr, pwdata, prdata, rd;
	int          num_errors, checks_done, n;
	wdsr_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .idle_mode(idle_mode), .other_reset_n(other_reset_n), .wdt_reset_req(wdt_reset_req));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic end_sim();
		$display("%0d checks, %0d mismatches", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(logic wr, logic [31:0] a, logic [7:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", {31'h0, pready}, 32'h1);
		if (pready !== 1'b1)
			end_sim();
		@(posedge pclk);
	endtask
	task automatic key(logic [7:0] a, logic [7:0] b);
		apb(1'b1, KA, a);
		apb(1'b1, KA, b);
	endtask
	task automatic ctrl(logic [31:0] exp);
		apb(1'b0, CA, 8'h00);
		chk("control", rd, exp);
	endtask
	// Bounded wait, then let the pulse and block reset finish
	task automatic wait_req(int lim);
		n = 0;
		while (wdt_reset_req !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
		chk("reset request", {31'h0, wdt_reset_req}, 32'h1);
		if (wdt_reset_req !== 1'b1)
			end_sim();
		repeat (8) @(posedge pclk);
	endtask
	task automatic quiet(int cyc);
		hit = 1'b0;
		repeat (cyc) begin
			@(posedge pclk);
			hit = hit | wdt_reset_req;
		end
		chk("no reset", {31'h0, hit}, 32'h0);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		idle_mode = 1'b0;
		other_reset_n = 1'b1;
		clk_en = 1'b1;
		num_errors = 0;
		checks_done = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		ctrl(32'h00);
		apb(1'b0, 32'h0000_0100, 8'h00);
		chk("unmapped error", {31'h0, err}, 32'h1);
		clk_en <= 1'b0;
		apb(1'b1, KA, 8'h33);
		quiet(20);
		clk_en <= 1'b1;
		ctrl(32'h00);
		$display("test registers done");
		key(8'h5A, 8'hA5);
		wait_req(20);
		ctrl(32'h04);
		apb(1'b1, CA, 8'h00);
		ctrl(32'h00);
		apb(1'b1, KA, 8'h33);
		wait_req(20);
		ctrl(32'h06);
		apb(1'b1, CA, 8'h00);
		key(8'h1E, 8'h5A);
		wait_req(20);
		ctrl(32'h06);
		apb(1'b1, CA, 8'h00);
		$display("test keys done");
		key(8'h1E, 8'hE1);
		ctrl(32'h01);
		apb(1'b1, CA, 8'hE0);
		ctrl(32'hE1);
		apb(1'b1, CA, 8'h00);
		ctrl(32'h01);
		quiet(10000);
		key(8'h1E, 8'hE1);
		quiet(10000);
		wait_req(7000);
		chk("time-out", {31'h0, n >= 6376 && n <= 6392}, 32'h1);
		ctrl(32'h02);
		$display("test time-out done");
		apb(1'b1, CA, 8'h10);
		key(8'h1E, 8'hE1);
		idle_mode <= 1'b1;
		quiet(20000);
		idle_mode <= 1'b0;
		wait_req(17000);
		ctrl(32'h02);
		apb(1'b1, CA, 8'h00);
		key(8'h1E, 8'hE1);
		other_reset_n <= 1'b0;
		repeat (4) @(posedge pclk);
		other_reset_n <= 1'b1;
		repeat (4) @(posedge pclk);
		ctrl(32'h00);
		$display("test idle and reset done");
		end_sim();
	end
endmodule
`default_nettype wire
